// ---- dv/smbc_monitor.sv ----
// assertion checker for the smbus control block ports
`timescale 1ns/100ps
`include "smbc_regs.vh"

module smbc_monitor (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire tmr3_split,
  input wire tmr3_reload_high,
  input wire tmr3_reload_low,
  input wire scl_in,
  input wire scl_oe,
  input wire sda_oe,
  input wire irq_flag
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire ctl_wr = sfr_wr && sfr_addr == `SMBC_CTL_ADDR;
  wire cfg_wr = sfr_wr && sfr_addr == `SMBC_CFG_ADDR;

  a_split_low_free: assert property (
    tmr3_reload_low |-> tmr3_reload_high && !$past(tmr3_split))
    else $error("low byte reload while split");
  a_reload_scl_low: assert property (
    (!scl_in)[*5] |-> !tmr3_reload_high)
    else $error("reload held while scl low");
  a_reload_cfg_off: assert property (
    cfg_wr && !sfr_wdata[`SMBC_TOE] |-> ##2 !tmr3_reload_high)
    else $error("reload without timeout enable");
  a_irq_holds_scl: assert property (
    irq_flag[*2] |-> scl_oe)
    else $error("scl not held during irq");
  a_irq_force: assert property (
    ctl_wr && sfr_wdata[`SMBC_SI] |=> irq_flag)
    else $error("irq not forced");
  a_irq_clear: assert property (
    ctl_wr && !sfr_wdata[`SMBC_SI] && irq_flag |=> !irq_flag)
    else $error("irq not cleared");
  a_irq_readback: assert property (
    sfr_addr == `SMBC_CTL_ADDR && !sfr_wr |=> sfr_rdata[0] == $past(irq_flag))
    else $error("irq bit read wrong");
  a_sda_hold: assert property (
    $rose(scl_oe) |=> $stable(sda_oe)[*3])
    else $error("sda hold too short");
  a_sda_setup: assert property (
    $fell(scl_oe) |-> $stable(sda_oe))
    else $error("sda setup too short");
  a_start_then_low: assert property (
    $rose(sda_oe) && !scl_oe && scl_in |-> ##[1:300] scl_oe)
    else $error("start not followed by scl low");

  c_irq: cover property ($rose(irq_flag));
  c_stop: cover property ($fell(sda_oe) && !scl_oe && scl_in);
  c_split: cover property (tmr3_reload_high && !tmr3_reload_low);
endmodule

bind smbc_ctrl smbc_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .tmr3_split(tmr3_split), .tmr3_reload_high(tmr3_reload_high),
  .tmr3_reload_low(tmr3_reload_low), .scl_in(scl_in), .scl_oe(scl_oe),
  .sda_oe(sda_oe), .irq_flag(irq_flag));

// ---- dv/smbc_peer.sv ----
// slave model on the two-wire bus, acks every byte it sees
`timescale 1ns/100ps

module smbc_peer (
  input wire scl,
  input wire sda,
  output reg sda_pull,
  output reg [7:0] last_byte,
  output reg [7:0] n_stops
);
  integer cnt;
  reg framed;
  reg [7:0] sh;
  // starts at 9 so power-up glitches on the lines count no bits
  initial begin
    sda_pull = 0;
    last_byte = 0;
    n_stops = 0;
    cnt = 9;
    framed = 0;
    sh = 0;
  end
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = 0;
    framed = 1;
  end
  always @(posedge sda) if (scl === 1'b1 && framed) begin
    n_stops = n_stops + 1;
    framed = 0;
  end
  always @(posedge scl) if (cnt < 8) begin
    sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // released line floats back to the pull-up level
  always @(negedge scl) begin
    if (sda_pull) begin
      sda_pull = 0;
      cnt = 0;
    end else if (cnt == 8) begin
      sda_pull = 1;
      last_byte = sh;
    end
  end
endmodule

// ---- dv/tb_smbc_ctrl.sv ----
// self-checking bench for the smbus control block
`timescale 1ns/100ps
`include "smbc_regs.vh"

module tb_smbc_ctrl;
  localparam [7:0] ctl_a = `SMBC_CTL_ADDR;
  localparam [7:0] cfg_a = `SMBC_CFG_ADDR;
  localparam [7:0] dat_a = `SMBC_DAT_ADDR;
  reg sys_clk, reset_n, sfr_wr, tmr3_split, tb_scl_low;
  reg [7:0] sfr_addr, sfr_wdata, seed, v;
  reg [3:0] ovf;
  reg [1:0] src;
  wire [7:0] sfr_rdata, peer_byte, peer_stops;
  wire tx_ready, rl_hi, rl_lo, scl_oe, sda_oe, irq_flag, peer_pull;
  integer num_errors, n_checks, cyc, i, k;
  reg [7:0] q[$];
  wire scl = !(scl_oe | tb_scl_low);
  wire sda = !(sda_oe | peer_pull);

  smbc_ctrl #(.FIFO_DEPTH(32), .FIFO_AW(5)) uut (.sys_clk(sys_clk), .reset_n(reset_n),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .tx_ready(tx_ready), .tmr0_ovf(ovf[0]), .tmr1_ovf(ovf[1]), .tmr2_high_ovf(ovf[2]),
    .tmr2_low_ovf(ovf[3]), .tmr3_split(tmr3_split), .tmr3_reload_high(rl_hi),
    .tmr3_reload_low(rl_lo), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .irq_flag(irq_flag));
  smbc_peer peer (.scl(scl), .sda(sda), .sda_pull(peer_pull), .last_byte(peer_byte),
    .n_stops(peer_stops));

  // ----------------------------------------
  // clock, overflow ticks, watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // only the selected source ticks, so a wrong select stalls the bus
  always @(posedge sys_clk) begin
    #1;
    cyc = cyc + 1;
    ovf = cyc[0] ? (4'h1 << src) : 4'h0;
    if (cyc > 40000) begin
      num_errors = num_errors + 1;
      conclude;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task conclude;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chkb(input string nm, input e, input g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge sys_clk);
    #1 sfr_wr = 0;
  endtask
  task rd(input [7:0] a, output [7:0] d);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    @(posedge sys_clk);
    #1 d = sfr_rdata;
  endtask
  task rchk(input [7:0] a, input [7:0] e, input string nm);
    reg [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task wait_irq;
    integer n;
    n = 0;
    while (irq_flag !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      #1 n = n + 1;
    end
    chkb("irq_set", 1'b1, irq_flag);
  endtask
  task wait_free;
    integer n;
    reg [7:0] d;
    n = 0;
    d = 8'h20;
    while (d[5] && n < 400) begin
      rd(cfg_a, d);
      n = n + 1;
    end
    chkb("busy_clear", 1'b0, d[5]);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    src = 0;
    ovf = 0;
    seed = 8'h56;
    reset_n = 0;
    sfr_wr = 0;
    sfr_addr = 0;
    sfr_wdata = 0;
    tmr3_split = 0;
    tb_scl_low = 0;
    repeat (4) @(posedge sys_clk);
    #1 reset_n = 1;
    rchk(cfg_a, 8'h00, "cfg_reset");
    rchk(ctl_a, 8'h00, "ctl_reset");
    rchk(8'hc5, 8'h00, "unmapped");
    wr(cfg_a, 8'hff);
    rchk(cfg_a, 8'hdf, "cfg_busy_ro");
    wr(cfg_a, 8'h88);
    repeat (4) @(posedge sys_clk);
    #1 chkb("reload_hi", 1'b1, rl_hi);
    chkb("reload_lo", 1'b1, rl_lo);
    tmr3_split = 1;
    repeat (3) @(posedge sys_clk);
    #1 chkb("split_lo", 1'b0, rl_lo);
    chkb("split_hi", 1'b1, rl_hi);
    tb_scl_low = 1;
    repeat (5) @(posedge sys_clk);
    #1 chkb("count_lo", 1'b0, rl_hi);
    tb_scl_low = 0;
    tmr3_split = 0;
    // timeout handler resets the link by a disable and re-enable
    wr(cfg_a, 8'h08);
    repeat (2) @(posedge sys_clk);
    #1 chkb("reload_dis", 1'b0, rl_hi);
    wr(cfg_a, 8'h88);
    wr(ctl_a, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chkb("irq_force", 1'b1, irq_flag);
    chkb("scl_stall", 1'b1, scl_oe);
    wr(ctl_a, 8'h00);
    chkb("irq_clr", 1'b0, irq_flag);
    for (k = 0; k < 4; k = k + 1) begin
      src = k[1:0];
      wr(cfg_a, {2'b10, 1'b0, k[0], 2'b01, src});
      seed = lfsr(seed);
      q.push_back(seed);
      wr(dat_a, seed);
      wr(ctl_a, 8'h20);
      wait_irq;
      rchk(ctl_a, 8'he1, "ctl_start");
      rd(cfg_a, v);
      chkb("busy", 1'b1, v[5]);
      wr(ctl_a, 8'h00);
      wait_irq;
      rd(ctl_a, v);
      chk("ctl_acked", 8'hc3, v & 8'hcf);
      chk("byte", q.pop_front(), peer_byte);
      wr(ctl_a, 8'h10);
      wait_free;
      chk("stops", 8'(k + 1), peer_stops);
    end
    for (i = 0; i < 32; i = i + 1) begin
      seed = lfsr(seed);
      q.push_back(seed);
      wr(dat_a, seed);
    end
    chkb("fifo_full", 1'b0, tx_ready);
    wr(dat_a, 8'h00);
    wr(ctl_a, 8'h20);
    wait_irq;
    for (i = 0; i < 32; i = i + 1) begin
      wr(ctl_a, 8'h00);
      // far side stretches the clock mid-drain
      if (i == 16) begin
        tb_scl_low = 1;
        repeat (24) @(posedge sys_clk);
        #1 tb_scl_low = 0;
      end
      wait_irq;
      chk("fifo_byte", q.pop_front(), peer_byte);
    end
    chkb("fifo_empty", 1'b1, tx_ready);
    wr(ctl_a, 8'h10);
    wait_free;
    conclude;
  end
endmodule

// ---- hw/smbc_ctrl.v ----
// smbus configuration, control flags and bit engine
`timescale 1ns/100ps
`include "smbc_regs.vh"

module smbc_ctrl #(
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output wire tx_ready,
  input wire tmr0_ovf,
  input wire tmr1_ovf,
  input wire tmr2_high_ovf,
  input wire tmr2_low_ovf,
  input wire tmr3_split,
  output reg tmr3_reload_high,
  output reg tmr3_reload_low,
  input wire scl_in,
  output wire scl_out,
  output reg scl_oe,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  output wire irq_flag
);

// ----------------------------------------------------------------
// state codes
// ----------------------------------------------------------------
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_WFREE = 3'h1;
localparam [2:0] S_START = 3'h2;
localparam [2:0] S_BIT = 3'h3;
localparam [2:0] S_TAIL = 3'h4;

reg [7:0] cfg;
reg busy;
reg master;
reg txm;
reg begin_condition_flag;
reg end_condition_flag;
reg ack_request_flag;
reg arb;
reg ack;
reg si;
reg [2:0] state;
reg [3:0] bit_cnt;
reg [7:0] shift;
reg [7:0] rx_data;
reg [1:0] tick_cnt;
reg [3:0] hold_cnt;
reg [3:0] setup_cnt;
reg [3:0] free_cnt;
reg scl_d;
reg sda_d;
reg ack_smp;
reg slave_blk;
reg slave_ign;
reg addr_phase;
reg post_start;
reg tail_stop;
reg tick;

wire scl_s;
wire sda_s;
wire fifo_valid;
wire [7:0] fifo_data;

// ----------------------------------------------------------------
// line synchronisers and transmit fifo
// ----------------------------------------------------------------
smbc_sync #(
  .WIDTH(2)
) u_sync (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .async_in({scl_in, sda_in}),
  .sync_out({scl_s, sda_s})
);

wire en = cfg[`SMBC_EN];
wire ctl_wr = sfr_wr & (sfr_addr == `SMBC_CTL_ADDR);
wire cfg_wr = sfr_wr & (sfr_addr == `SMBC_CFG_ADDR);
wire dat_wr = sfr_wr & (sfr_addr == `SMBC_DAT_ADDR);
wire launch = ctl_wr & ~sfr_wdata[`SMBC_SI] & si;
// flags written together with the irq clear must steer that same launch
wire next_sta = ctl_wr ? sfr_wdata[`SMBC_STA] : begin_condition_flag;
wire next_sto = (ctl_wr & (master | ~sfr_wdata[`SMBC_STO])) ? sfr_wdata[`SMBC_STO] : end_condition_flag;
wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_det = en & scl_s & scl_d & sda_d & ~sda_s;
wire stop_det = en & scl_s & scl_d & ~sda_d & sda_s;
wire free_to = free_cnt > `SMBC_FREE_PERIODS;
wire hold_ok = hold_cnt >= (cfg[`SMBC_EXT] ? `SMBC_HOLD_EXT : `SMBC_HOLD_NORM);
wire setup_ok = setup_cnt >= (cfg[`SMBC_EXT] ? `SMBC_SETUP_EXT : `SMBC_SETUP_NORM);
wire phase_done = tick_cnt == `SMBC_PHASE_TICKS;
wire quiet = ~master & (slave_blk | slave_ign);
wire scl_low_seen = ~scl_s & ~scl_d;
wire drv_low = (txm & ~bit_cnt[3]) ? ~shift[7] : (~txm & bit_cnt[3] & ack & ~quiet);
wire load_byte = launch & (state == S_BIT) & (bit_cnt == 4'h0) &
  ~(master & (next_sto | (next_sta & ~post_start)));
wire take = load_byte & (master | txm) & fifo_valid;

// a full fifo refuses the write; tx_ready tells software to back off
smbc_fifo #(
  .WIDTH(8),
  .DEPTH(FIFO_DEPTH),
  .AW(FIFO_AW)
) u_fifo (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .in_valid(dat_wr),
  .in_ready(tx_ready),
  .in_data(sfr_wdata),
  .out_valid(fifo_valid),
  .out_ready(take),
  .out_data(fifo_data)
);

assign scl_out = 1'b0;
assign sda_out = 1'b0;
assign irq_flag = si;

// ----------------------------------------------------------------
// bit clock source
// ----------------------------------------------------------------
always @* begin
  case (cfg[`SMBC_CS_HI:`SMBC_CS_LO])
    2'h0: tick = tmr0_ovf;
    2'h1: tick = tmr1_ovf;
    2'h2: tick = tmr2_high_ovf;
    default: tick = tmr2_low_ovf;
  endcase
end

// ----------------------------------------------------------------
// register read
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    sfr_rdata <= 8'h00;
  end else begin
    case (sfr_addr)
      `SMBC_CFG_ADDR: sfr_rdata <= {cfg[7:6], busy, cfg[4:0]};
      `SMBC_CTL_ADDR: sfr_rdata <= {master, txm, begin_condition_flag, end_condition_flag, ack_request_flag, arb, ack, si};
      `SMBC_DAT_ADDR: sfr_rdata <= rx_data;
      default: sfr_rdata <= 8'h00;
    endcase
  end
end

// ----------------------------------------------------------------
// flags and engine
// ----------------------------------------------------------------
always @(posedge sys_clk) begin
  if (!reset_n) begin
    cfg <= `SMBC_CFG_RESET;
    {master, txm, begin_condition_flag, end_condition_flag, ack_request_flag, arb, ack, si} <= `SMBC_CTL_RESET;
    busy <= 1'b0;
    state <= S_IDLE;
    bit_cnt <= 4'h0;
    shift <= 8'h00;
    rx_data <= 8'h00;
    tick_cnt <= 2'h0;
    hold_cnt <= 4'h0;
    setup_cnt <= 4'h0;
    free_cnt <= 4'h0;
    scl_d <= 1'b1;
    sda_d <= 1'b1;
    ack_smp <= 1'b0;
    slave_blk <= 1'b0;
    slave_ign <= 1'b0;
    addr_phase <= 1'b0;
    post_start <= 1'b0;
    tail_stop <= 1'b0;
    scl_oe <= 1'b0;
    sda_oe <= 1'b0;
    tmr3_reload_high <= 1'b0;
    tmr3_reload_low <= 1'b0;
  end else begin
    scl_d <= scl_s;
    sda_d <= sda_s;
    tmr3_reload_high <= en & cfg[`SMBC_TOE] & scl_s;
    tmr3_reload_low <= en & cfg[`SMBC_TOE] & scl_s & ~tmr3_split;
    if (~en | ~cfg[`SMBC_FTE] | ~scl_s | ~sda_s) begin
      free_cnt <= 4'h0;
    end else if (tick & ~free_to) begin
      free_cnt <= free_cnt + 4'h1;
    end
    if (start_det) begin
      busy <= 1'b1;
    end else if (~en | stop_det | free_to) begin
      busy <= 1'b0;
    end
    // hold is timed from the fall as seen through the synchroniser
    if (scl_fall) begin
      hold_cnt <= 4'h0;
    end else if (hold_cnt != 4'hf) begin
      hold_cnt <= hold_cnt + 4'h1;
    end
    if (setup_cnt != 4'hf) begin
      setup_cnt <= setup_cnt + 4'h1;
    end
    if (tick & ~phase_done) begin
      tick_cnt <= tick_cnt + 2'h1;
    end
    // software writes first, so hardware sets below win
    if (cfg_wr) begin
      cfg <= {sfr_wdata[7:6], 1'b0, sfr_wdata[4:0]};
    end
    if (ctl_wr) begin
      begin_condition_flag <= sfr_wdata[`SMBC_STA];
      if (master | ~sfr_wdata[`SMBC_STO]) begin
        end_condition_flag <= sfr_wdata[`SMBC_STO];
      end
      ack <= sfr_wdata[`SMBC_ACK];
      si <= sfr_wdata[`SMBC_SI];
    end
    if (launch) begin
      arb <= 1'b0;
    end
    case (state)
      S_IDLE: begin
        scl_oe <= si;
        sda_oe <= 1'b0;
        if (begin_condition_flag) begin
          state <= S_WFREE;
        end
      end
      S_WFREE: begin
        if (~busy & scl_s & sda_s) begin
          sda_oe <= 1'b1;
          tick_cnt <= 2'h0;
          state <= S_START;
        end
      end
      S_START: begin
        if (phase_done) begin
          scl_oe <= 1'b1;
        end
        // wait for the start's own scl fall so it is not counted as a data bit
        if (scl_oe & scl_low_seen) begin
          master <= 1'b1;
          txm <= 1'b1;
          si <= 1'b1;
          post_start <= 1'b1;
          bit_cnt <= 4'h0;
          tick_cnt <= 2'h0;
          state <= S_BIT;
        end
      end
      S_BIT: begin
        // data moves only once scl is seen low and the hold time has passed
        if (hold_ok & scl_low_seen & (sda_oe != drv_low)) begin
          sda_oe <= drv_low;
          setup_cnt <= 4'h0;
        end
        if (master) begin
          if (scl_oe) begin
            if (phase_done & hold_ok & setup_ok & ~si & (sda_oe == drv_low)) begin
              scl_oe <= 1'b0;
              tick_cnt <= 2'h0;
            end
          end else if (~scl_s) begin
            tick_cnt <= 2'h0;
          end else if (phase_done | si) begin
            scl_oe <= 1'b1;
            tick_cnt <= 2'h0;
          end
        end else begin
          scl_oe <= si;
        end
        if (scl_rise) begin
          if (~bit_cnt[3]) begin
            shift <= {shift[6:0], sda_s};
            if (txm & ~sda_oe & ~sda_s) begin
              arb <= 1'b1;
              si <= 1'b1;
              master <= 1'b0;
              txm <= 1'b0;
              state <= S_IDLE;
            end
          end else begin
            ack_smp <= ~sda_s;
          end
        end
        if (scl_fall) begin
          if (bit_cnt == 4'h7) begin
            bit_cnt <= 4'h8;
            if (~txm) begin
              rx_data <= shift;
              ack <= 1'b0;
              if (~quiet) begin
                ack_request_flag <= 1'b1;
                si <= 1'b1;
                if (addr_phase) begin
                  begin_condition_flag <= 1'b1;
                end
              end
            end
          end else if (bit_cnt[3]) begin
            bit_cnt <= 4'h0;
            ack_request_flag <= 1'b0;
            addr_phase <= 1'b0;
            if (txm) begin
              ack <= ack_smp;
              si <= 1'b1;
            end else if (master & end_condition_flag) begin
              tail_stop <= 1'b1;
              tick_cnt <= 2'h0;
              state <= S_TAIL;
            end else if (addr_phase & ~master) begin
              if (~ack | quiet) begin
                slave_ign <= 1'b1;
              end else begin
                txm <= shift[0];
                si <= shift[0];
              end
            end
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        if (launch & (bit_cnt == 4'h0) & master) begin
          if (next_sto) begin
            tail_stop <= 1'b1;
            tick_cnt <= 2'h0;
            state <= S_TAIL;
          end else if (next_sta & ~post_start) begin
            tail_stop <= 1'b0;
            tick_cnt <= 2'h0;
            state <= S_TAIL;
          end
        end
        if (load_byte) begin
          post_start <= 1'b0;
          if (master) begin
            txm <= fifo_valid;
          end
          if (take) begin
            shift <= fifo_data;
          end else if (~master & txm) begin
            shift <= 8'hff;
          end
        end
      end
      S_TAIL: begin
        // stop: sda low then high under scl high; repeated start is the mirror
        if (scl_oe) begin
          if (hold_ok & scl_low_seen & (sda_oe != tail_stop)) begin
            sda_oe <= tail_stop;
            setup_cnt <= 4'h0;
          end
          if (phase_done & setup_ok & (sda_oe == tail_stop)) begin
            scl_oe <= 1'b0;
            tick_cnt <= 2'h0;
          end
        end else if (~scl_s) begin
          tick_cnt <= 2'h0;
        end else if (phase_done) begin
          tick_cnt <= 2'h0;
          if (tail_stop) begin
            sda_oe <= 1'b0;
            master <= 1'b0;
            txm <= 1'b0;
            end_condition_flag <= 1'b0;
            state <= begin_condition_flag ? S_WFREE : S_IDLE;
          end else begin
            sda_oe <= 1'b1;
            state <= S_START;
          end
        end
      end
      default: begin
        state <= S_IDLE;
      end
    endcase
    if (stop_det & ~master & (state == S_BIT)) begin
      state <= S_IDLE;
      if (~quiet) begin
        end_condition_flag <= 1'b1;
        si <= 1'b1;
      end
    end
    // inhibit takes effect from the start that opens a transfer
    if (start_det & ~master & ((state == S_IDLE) | (state == S_WFREE) | (state == S_BIT))) begin
      state <= S_BIT;
      bit_cnt <= 4'h0;
      txm <= 1'b0;
      addr_phase <= 1'b1;
      slave_ign <= 1'b0;
      slave_blk <= cfg[`SMBC_INH];
    end
    if (~en) begin
      state <= S_IDLE;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      master <= 1'b0;
      txm <= 1'b0;
      slave_ign <= 1'b0;
    end
  end
end

endmodule

// ---- hw/smbc_fifo.v ----
// transmit byte fifo, flip-flop storage
`timescale 1ns/100ps

module smbc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

localparam [AW:0] FULL_CNT = DEPTH[AW:0];

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW:0] wr_ptr;
reg [AW:0] rd_ptr;
wire [AW:0] fill = wr_ptr - rd_ptr;

assign in_ready = fill != FULL_CNT;
assign out_valid = fill != {(AW+1){1'b0}};
assign out_data = mem[rd_ptr[AW-1:0]];

always @(posedge sys_clk) begin
  if (in_valid & in_ready) begin
    mem[wr_ptr[AW-1:0]] <= in_data;
  end
end

always @(posedge sys_clk) begin
  if (!reset_n) begin
    wr_ptr <= {(AW+1){1'b0}};
    rd_ptr <= {(AW+1){1'b0}};
  end else begin
    if (in_valid & in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
    if (out_ready & out_valid) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
end

endmodule

// ---- hw/smbc_regs.vh ----
// register map, field positions, reset values and timing counts of the smbus control block
//
// Function
// - interface enable bit turns the interface on and keeps both lines monitored.
// - slave event block bit suppresses slave interrupts; master interrupts stay unaffected.
// - busy indicator sets during a transfer, clears on stop or bus-free timeout.
// - sda timing extension bit picks normal or extended sda setup and hold.
// - normal hold is three clocks; extended setup eleven and hold twelve clocks.
// - scl low timeout enable holds timeout timer in reload while scl is high.
// - with a split timeout timer only its high byte is held in reload.
// - bus-free timeout: bus free after both lines high over ten source periods.
// - clock source select: timer0, timer1, timer2 high byte, timer2 low byte overflow.
// - as master each scl low and high phase lasts two overflow periods.
// - upper control bits report role, direction, begin and end condition flags.
// - begin and end flags report a start or stop seen since last interrupt.
// - writing begin flag makes master start once bus is free; flag stays set.
// - writing end flag as master sends stop after the next ack cycle.
// - both flags set in master mode give a stop followed by a start.
// - receiver drives written ack bit; transmitter shows last sampled ack there.
// - ack request flag sets on every received byte, except while slave events are blocked or ignored.
// - software writes ack before clearing interrupt flag, otherwise a nack goes out.
// - sda takes a new ack value at once; scl stays low until flag clears.
// - after a nacked slave address, slave events are ignored until next start.
// - arbitration loss flag sets on lost arbitration; clears with interrupt flag.
// - interrupt flag sets at transfer start and end, each byte, arbitration loss.
// - while interrupt flag is set the interface stalls with scl held low.
// - writing 0 to interrupt flag clears it and launches next event; 1 forces it.
`ifndef SMBC_REGS_VH
`define SMBC_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SMBC_CTL_ADDR 8'hc0
`define SMBC_CFG_ADDR 8'hc1
`define SMBC_DAT_ADDR 8'hc2

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define SMBC_EN 7
`define SMBC_INH 6
`define SMBC_BUSY 5
`define SMBC_EXT 4
`define SMBC_TOE 3
`define SMBC_FTE 2
`define SMBC_CS_HI 1
`define SMBC_CS_LO 0
`define SMBC_CFG_RESET 8'h00

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define SMBC_MST 7
`define SMBC_TXM 6
`define SMBC_STA 5
`define SMBC_STO 4
`define SMBC_ACK_REQUEST_FLAG 3
`define SMBC_ARB 2
`define SMBC_ACK 1
`define SMBC_SI 0
`define SMBC_CTL_RESET 8'h00

// ----------------------------------------------------------------
// timing counts, in system clocks or source overflows
// ----------------------------------------------------------------
`define SMBC_HOLD_NORM 4'h3
`define SMBC_HOLD_EXT 4'hc
`define SMBC_SETUP_NORM 4'h1
`define SMBC_SETUP_EXT 4'hb
`define SMBC_FREE_PERIODS 4'ha
`define SMBC_PHASE_TICKS 2'h2

`endif

// ---- hw/smbc_sync.v ----
// two-flop synchronisers for the bus lines
`timescale 1ns/100ps

module smbc_sync #(
  parameter WIDTH = 2
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

genvar i;
generate
  for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
    reg meta;
    reg stable;
    // reset high: an idle bus line floats high
    always @(posedge sys_clk) begin
      if (!reset_n) begin
        meta <= 1'b1;
        stable <= 1'b1;
      end else begin
        meta <= async_in[i];
        stable <= meta;
      end
    end
    assign sync_out[i] = stable;
  end
endgenerate

endmodule
